// ### shared/axis_amp_pkg.sv
// Constants, register map and state layout of the axis commutation and amplifier enable block.
// Assumes a single 100 MHz APB clock domain and eight physical axis slots.
package axis_amp_pkg;
  localparam int NUM_AXES = 8;
  localparam int DAC_W = 16;
  localparam int POS_W = 32;
  localparam int DIN_W = 96;

  // ****************************************
  // Register byte addresses.
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COMM_SEL = 8'h04;
  localparam logic [7:0] OFS_MOTOR = 8'h08;
  localparam logic [7:0] OFS_OFF_ON_ERR = 8'h0C;
  localparam logic [7:0] OFS_ERR_LIMIT = 8'h10;
  localparam logic [7:0] OFS_ENC_MODE = 8'h14;
  localparam logic [7:0] OFS_POS_QUERY = 8'h18;
  localparam logic [7:0] OFS_POS_DATA = 8'h1C;
  localparam logic [7:0] OFS_HALL_SEL0 = 8'h20;
  localparam logic [7:0] OFS_HALL_SEL1 = 8'h24;
  localparam logic [7:0] OFS_PHASE = 8'h28;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h2C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h30;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h34;
  localparam logic [7:0] OFS_INDEX_DATA = 8'h38;

  // ****************************************
  // Field positions and reset values.
  // ****************************************
  localparam int CTRL_AXES_LSB = 0;
  localparam int CTRL_POL_BIT = 4;
  localparam int MOTOR_ON_LSB = 8;
  localparam int IRQ_REJECT_BIT = 8;
  localparam int IRQ_W = 9;
  localparam logic [3:0] RST_AXES = 4'h8;
  localparam logic [15:0] RST_ERR_LIMIT = 16'h07D0;

  // ****************************************
  // Hall input ranges, numbered from one.
  // ****************************************
  localparam logic [7:0] HALL_GEN_LO = 8'h01;
  localparam logic [7:0] HALL_GEN_HI = 8'h08;
  localparam logic [7:0] HALL_EXT_LO = 8'h11;
  localparam logic [7:0] HALL_EXT_HI = 8'h50;
  localparam logic [7:0] HALL_AUX_LO = 8'h51;
  localparam logic [7:0] HALL_AUX_HI = 8'h60;

  typedef struct packed {
    logic [3:0] axes;
    logic pol;
    logic [7:0] comm;
    logic [7:0] motor_on;
    logic [7:0] oe;
    logic [15:0] lim;
    logic [7:0] pd;
    logic [2:0] qsel;
    logic [POS_W-1:0] snap;
    logic [POS_W-1:0] isnap;
    logic [7:0][7:0] hall;
    logic [7:0] hall_done;
    logic [7:0][2:0] sector;
    logic [IRQ_W-1:0] ista;
    logic [IRQ_W-1:0] ien;
    logic [7:0][POS_W-1:0] pos;
    logic [7:0][POS_W-1:0] idxpos;
    logic [7:0] ea;
    logic [7:0] eb;
    logic [7:0] ei;
    logic [7:0][DAC_W-1:0] dac;
    logic [7:0] amp;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } axis_state_t;
endpackage

// ### rtl/axis_commutation_amp_enable.sv
// Axis commutation output routing, amplifier enables, encoder counters and hall phase estimate.
// Assumes an APB master on pclk and encoder, hall and command inputs synchronous to pclk.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module axis_commutation_amp_enable (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdog_trip,
  input wire logic [7:0][15:0] pos_err_abs,
  input wire logic [7:0][15:0] axis_cmd,
  input wire logic [7:0][15:0] phase_b_cmd,
  input wire logic [7:0] encoder_channel_a,
  input wire logic [7:0] encoder_channel_b,
  input wire logic [7:0] encoder_index,
  input wire logic [95:0] digital_in,
  output logic [7:0][15:0] dac_out,
  output logic [7:0] amp_enable_out,
  output logic irq
);

  axis_amp_pkg::axis_state_t st_r;
  axis_amp_pkg::axis_state_t st_nxt;

  // ****************************************
  // Hall helpers.
  // ****************************************
  function automatic logic hall_start_ok(input logic [7:0] s);
    hall_start_ok = (s >= axis_amp_pkg::HALL_GEN_LO && s <= axis_amp_pkg::HALL_GEN_HI - 8'h02) ||
                    (s >= axis_amp_pkg::HALL_EXT_LO && s <= axis_amp_pkg::HALL_EXT_HI - 8'h02) ||
                    (s >= axis_amp_pkg::HALL_AUX_LO && s <= axis_amp_pkg::HALL_AUX_HI - 8'h02);
  endfunction

  function automatic logic [3:0] hall_sector(input logic [2:0] h);
    unique case (h)
      3'h1: hall_sector = 4'h0;
      3'h3: hall_sector = 4'h1;
      3'h2: hall_sector = 4'h2;
      3'h6: hall_sector = 4'h3;
      3'h4: hall_sector = 4'h4;
      3'h5: hall_sector = 4'h5;
      default: hall_sector = 4'h8;
    endcase
  endfunction

  logic wr_en;
  logic rd_setup;
  logic [3:0] ncomm;
  logic [3:0] base;
  logic [7:0] trip;
  logic [7:0] hall_ok0;

  assign wr_en = psel & penable & pwrite & st_r.pready;
  assign rd_setup = psel & ~penable;

  always_comb begin
    logic [3:0] rank;
    logic [3:0] slot;
    logic [7:0] hs;
    logic [3:0] sec;
    logic [axis_amp_pkg::POS_W-1:0] p;
    st_nxt = st_r;
    rank = 4'h0;
    slot = 4'h0;
    hs = 8'h00;
    sec = 4'h0;
    p = '0;
    ncomm = 4'h0;
    trip = 8'h00;
    hall_ok0 = 8'h00;
    for (int i = 0; i < 8; i++) begin
      ncomm = ncomm + {3'h0, st_r.comm[i]};
    end
    base = st_r.axes - ncomm;

    // ****************************************
    // Register writes.
    // ****************************************
    for (int i = 0; i < 4; i++) begin
      hall_ok0[i] = (pwdata[8*i+:8] == 8'h00) || hall_start_ok(pwdata[8*i+:8]);
    end
    if (wr_en) begin
      unique case (paddr)
        axis_amp_pkg::OFS_CTRL: begin
          if (pwdata[axis_amp_pkg::CTRL_AXES_LSB+:4] != 4'h0 &&
              pwdata[axis_amp_pkg::CTRL_AXES_LSB+:4] <= 4'h8) begin
            st_nxt.axes = pwdata[axis_amp_pkg::CTRL_AXES_LSB+:4];
            st_nxt.comm = 8'h00;
          end
          st_nxt.pol = pwdata[axis_amp_pkg::CTRL_POL_BIT];
        end
        axis_amp_pkg::OFS_COMM_SEL: begin
          slot = 4'h0;
          for (int i = 0; i < 8; i++) begin
            slot = slot + {3'h0, pwdata[i]};
          end
          // Every commutated axis must stay below the outputs that its choice frees.
          if ((pwdata[7:0] >> (st_r.axes - slot)) == 8'h00 &&
              {slot, 1'b0} <= {1'b0, st_r.axes}) begin
            st_nxt.comm = pwdata[7:0];
          end else begin
            st_nxt.ista[axis_amp_pkg::IRQ_REJECT_BIT] = 1'b1;
          end
        end
        axis_amp_pkg::OFS_MOTOR: begin
          st_nxt.motor_on = (st_r.motor_on | pwdata[axis_amp_pkg::MOTOR_ON_LSB+:8]) &
                            ~pwdata[7:0];
        end
        axis_amp_pkg::OFS_OFF_ON_ERR: st_nxt.oe = pwdata[7:0];
        axis_amp_pkg::OFS_ERR_LIMIT: st_nxt.lim = pwdata[15:0];
        axis_amp_pkg::OFS_ENC_MODE: st_nxt.pd = pwdata[7:0];
        axis_amp_pkg::OFS_POS_QUERY: begin
          st_nxt.qsel = pwdata[2:0];
          st_nxt.snap = st_r.pos[pwdata[2:0]];
          st_nxt.isnap = st_r.idxpos[pwdata[2:0]];
        end
        axis_amp_pkg::OFS_HALL_SEL0, axis_amp_pkg::OFS_HALL_SEL1: begin
          if (&hall_ok0[3:0]) begin
            for (int i = 0; i < 4; i++) begin
              st_nxt.hall[i + (paddr[2] ? 4 : 0)] = pwdata[8*i+:8];
              st_nxt.hall_done[i + (paddr[2] ? 4 : 0)] = 1'b0;
            end
          end else begin
            st_nxt.ista[axis_amp_pkg::IRQ_REJECT_BIT] = 1'b1;
          end
        end
        axis_amp_pkg::OFS_PHASE: begin
          for (int i = 0; i < 8; i++) begin
            st_nxt.sector[i] = pwdata[3*i+:3];
          end
        end
        axis_amp_pkg::OFS_IRQ_ENABLE: st_nxt.ien = pwdata[axis_amp_pkg::IRQ_W-1:0];
        axis_amp_pkg::OFS_IRQ_CLEAR: st_nxt.ista = st_nxt.ista & ~pwdata[axis_amp_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end

    // ****************************************
    // Amplifier enables.
    // ****************************************
    for (int i = 0; i < 8; i++) begin
      trip[i] = watchdog_trip | (st_r.oe[i] & (pos_err_abs[i] > st_r.lim));
      if (trip[i]) begin
        st_nxt.motor_on[i] = 1'b0;
        if (st_r.motor_on[i]) begin
          st_nxt.ista[i] = 1'b1;
        end
      end
    end
    st_nxt.amp = st_nxt.motor_on ^ {8{st_nxt.pol}};

    // ****************************************
    // Encoder counters.
    // ****************************************
    for (int i = 0; i < 8; i++) begin
      p = st_r.pos[i];
      if (st_r.pd[i]) begin
        if (encoder_channel_a[i] & ~st_r.ea[i]) begin
          p = encoder_channel_b[i] ? p - 32'h0000_0001 : p + 32'h0000_0001;
        end
      end else if ((encoder_channel_a[i] ^ st_r.ea[i]) != (encoder_channel_b[i] ^ st_r.eb[i])) begin
        // Exactly one channel moved; a lone toggling channel steps one count and then back, in either order.
        p = (encoder_channel_a[i] ^ st_r.eb[i]) ? p + 32'h0000_0001 : p - 32'h0000_0001;
      end
      st_nxt.pos[i] = p;
      if (encoder_index[i] & ~st_r.ei[i]) begin
        st_nxt.idxpos[i] = p;
      end
    end
    st_nxt.ea = encoder_channel_a;
    st_nxt.eb = encoder_channel_b;
    st_nxt.ei = encoder_index;

    // ****************************************
    // Hall phase estimate.
    // ****************************************
    for (int i = 0; i < 8; i++) begin
      hs = st_r.hall[i] - 8'h01;
      sec = hall_sector(digital_in[hs[6:0]+:3]);
      if (st_r.hall[i] != 8'h00 && !st_r.hall_done[i] && !sec[3]) begin
        st_nxt.sector[i] = sec[2:0];
        st_nxt.hall_done[i] = 1'b1;
      end
    end

    // ****************************************
    // Command output routing.
    // ****************************************
    for (int d = 0; d < 8; d++) begin
      st_nxt.dac[d] = 16'h0000;
      if (4'(d) < base) begin
        st_nxt.dac[d] = axis_cmd[d];
        if (st_r.comm[d] && !st_r.motor_on[d]) begin
          st_nxt.dac[d] = 16'h0000;
        end
      end else if (4'(d) < st_r.axes) begin
        rank = 4'h0;
        for (int a = 0; a < 8; a++) begin
          if (st_r.comm[a]) begin
            // Lowest commutated axis (X first) meets the lowest freed output.
            if (rank == 4'(d) - base) begin
              st_nxt.dac[d] = st_r.motor_on[a] ? phase_b_cmd[a] : 16'h0000;
            end
            rank = rank + 4'h1;
          end
        end
      end
    end
    st_nxt.irq = |(st_nxt.ista & st_nxt.ien);

    // ****************************************
    // APB read path.
    // ****************************************
    st_nxt.pready = rd_setup;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (rd_setup) begin
      unique case (paddr)
        axis_amp_pkg::OFS_CTRL: st_nxt.prdata = {27'h0, st_r.pol, st_r.axes};
        axis_amp_pkg::OFS_COMM_SEL: st_nxt.prdata = {24'h0, st_r.comm};
        axis_amp_pkg::OFS_MOTOR: st_nxt.prdata = {16'h0, st_r.motor_on, 8'h00};
        axis_amp_pkg::OFS_OFF_ON_ERR: st_nxt.prdata = {24'h0, st_r.oe};
        axis_amp_pkg::OFS_ERR_LIMIT: st_nxt.prdata = {16'h0, st_r.lim};
        axis_amp_pkg::OFS_ENC_MODE: st_nxt.prdata = {24'h0, st_r.pd};
        axis_amp_pkg::OFS_POS_QUERY: st_nxt.prdata = {29'h0, st_r.qsel};
        axis_amp_pkg::OFS_POS_DATA: st_nxt.prdata = st_r.snap;
        axis_amp_pkg::OFS_HALL_SEL0: st_nxt.prdata = {st_r.hall[3], st_r.hall[2], st_r.hall[1], st_r.hall[0]};
        axis_amp_pkg::OFS_HALL_SEL1: st_nxt.prdata = {st_r.hall[7], st_r.hall[6], st_r.hall[5], st_r.hall[4]};
        axis_amp_pkg::OFS_PHASE: st_nxt.prdata = {st_r.hall_done, st_r.sector};
        axis_amp_pkg::OFS_IRQ_STATUS: st_nxt.prdata = {23'h0, st_r.ista};
        axis_amp_pkg::OFS_IRQ_ENABLE: st_nxt.prdata = {23'h0, st_r.ien};
        axis_amp_pkg::OFS_IRQ_CLEAR: st_nxt.prdata = 32'h0000_0000;
        axis_amp_pkg::OFS_INDEX_DATA: st_nxt.prdata = st_r.isnap;
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.axes <= axis_amp_pkg::RST_AXES;
      st_r.lim <= axis_amp_pkg::RST_ERR_LIMIT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign dac_out = st_r.dac;
  assign amp_enable_out = st_r.amp;
  assign irq = st_r.irq;

  // ****************************************
  // Checks.
  // ****************************************
  property p_comm_reject;
    @(posedge pclk) disable iff (!presetn)
      wr_en && paddr == axis_amp_pkg::OFS_COMM_SEL && pwdata[st_r.axes - 4'h1] |=>
        $stable(st_r.comm) && st_r.ista[axis_amp_pkg::IRQ_REJECT_BIT];
  endproperty
  a_comm_reject: assert property (p_comm_reject) else $error("highest axis accepted for commutation");

  property p_wd_off;
    @(posedge pclk) disable iff (!presetn)
      watchdog_trip && !st_r.pol |=> amp_enable_out == 8'h00 [*1];
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("enable stayed on after watchdog trip");

  property p_amp_level;
    @(posedge pclk) disable iff (!presetn)
      amp_enable_out == (st_r.motor_on ^ {8{st_r.pol}});
  endproperty
  a_amp_level: assert property (p_amp_level) else $error("enable level does not follow motor state");

  property p_phase_a;
    @(posedge pclk) disable iff (!presetn)
      st_r.comm[0] && st_r.motor_on[0] && !wr_en |=> dac_out[0] == $past(axis_cmd[0]);
  endproperty
  a_phase_a: assert property (p_phase_a) else $error("first phase not on own output");

  property p_zero_off;
    @(posedge pclk) disable iff (!presetn)
      st_r.comm[0] && !st_r.motor_on[0] |=> dac_out[0] == 16'h0000;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("disabled commutated axis drives output");

  property p_freed_top;
    @(posedge pclk) disable iff (!presetn)
      st_r.axes == 4'h8 && st_r.comm == 8'h03 && st_r.motor_on[1] |=>
        dac_out[7] == $past(phase_b_cmd[1]);
  endproperty
  a_freed_top: assert property (p_freed_top) else $error("second phase not on highest output");

  property p_seven_xz;
    @(posedge pclk) disable iff (!presetn)
      st_r.axes == 4'h7 && st_r.comm == 8'h05 && st_r.motor_on[0] && st_r.motor_on[2] |=>
        dac_out[5] == $past(phase_b_cmd[0]) && dac_out[6] == $past(phase_b_cmd[2]);
  endproperty
  a_seven_xz: assert property (p_seven_xz) else $error("seven axis X Z mapping wrong");

  property p_one_channel;
    @(posedge pclk) disable iff (!presetn)
      !st_r.pd[3] && encoder_channel_a[3] != st_r.ea[3] && encoder_channel_b[3] == st_r.eb[3] |=>
        (st_r.pos[3] - $past(st_r.pos[3])) == 32'h0000_0001 ||
        ($past(st_r.pos[3]) - st_r.pos[3]) == 32'h0000_0001;
  endproperty
  a_one_channel: assert property (p_one_channel) else $error("single channel step not one count");

  property p_pulse_dir;
    @(posedge pclk) disable iff (!presetn)
      st_r.pd[2] && encoder_channel_a[2] && !st_r.ea[2] && !encoder_channel_b[2] |=>
        st_r.pos[2] == $past(st_r.pos[2]) + 32'h0000_0001;
  endproperty
  a_pulse_dir: assert property (p_pulse_dir) else $error("pulse did not count up");

  property p_trip_err;
    @(posedge pclk) disable iff (!presetn)
      !wr_en && !st_r.pol && st_r.oe[1] && pos_err_abs[1] > st_r.lim |=> !amp_enable_out[1];
  endproperty
  a_trip_err: assert property (p_trip_err) else $error("enable stayed on with excess error");

  property p_hall_reject;
    @(posedge pclk) disable iff (!presetn)
      wr_en && (paddr == axis_amp_pkg::OFS_HALL_SEL0 || paddr == axis_amp_pkg::OFS_HALL_SEL1) &&
        pwdata[7:0] > axis_amp_pkg::HALL_AUX_HI - 8'h02 |=>
        $stable(st_r.hall) && st_r.ista[axis_amp_pkg::IRQ_REJECT_BIT];
  endproperty
  a_hall_reject: assert property (p_hall_reject) else $error("bad hall start accepted");

  property p_hall_est;
    @(posedge pclk) disable iff (!presetn)
      !wr_en && st_r.hall[2] == 8'h06 && !st_r.hall_done[2] && digital_in[7:5] == 3'h3 |=>
        st_r.hall_done[2] && st_r.sector[2] == 3'h1;
  endproperty
  a_hall_est: assert property (p_hall_est) else $error("hall sector not estimated");

  property p_index_latch;
    @(posedge pclk) disable iff (!presetn)
      encoder_index[2] && !st_r.ei[2] |=> st_r.idxpos[2] == st_r.pos[2];
  endproperty
  a_index_latch: assert property (p_index_latch) else $error("index did not latch count");

  property p_bus_ready;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready;
  endproperty
  a_bus_ready: assert property (p_bus_ready) else $error("no ready after setup cycle");

endmodule

`default_nettype wire

// ### bench/axis_far_side.sv
// Far-side model: encoder and hall sensor signals of each axis.
// Assumes the bench calls its tasks from a process that follows pclk.
`timescale 1ns/100ps
`default_nettype none
module axis_far_side (
  input wire logic pclk,
  output logic [7:0] enc_a,
  output logic [7:0] enc_b,
  output logic [7:0] enc_i,
  output logic [95:0] din
);
  logic [7:0][1:0] ph;
  initial begin
    enc_a = 8'h00;
    enc_b = 8'h00;
    enc_i = 8'h00;
    din = 96'h0;
    ph = 16'h0000;
  end
  // ****
  // Encoder and hall stimulus.
  // ****
  task automatic quad(input int ax, input logic up);
    @(posedge pclk);
    ph[ax] = ph[ax] + (up ? 2'h1 : 2'h3);
    enc_a[ax] <= ph[ax][1];
    enc_b[ax] <= ph[ax][1] ^ ph[ax][0];
  endtask
  task automatic tog(input int ax);
    @(posedge pclk);
    enc_a[ax] <= ~enc_a[ax];
  endtask
  task automatic pulse(input int ax, input logic dn);
    @(posedge pclk);
    enc_b[ax] <= dn;
    @(posedge pclk);
    enc_a[ax] <= 1'b1;
    @(posedge pclk);
    enc_a[ax] <= 1'b0;
  endtask
  task automatic idx(input int ax);
    @(posedge pclk);
    enc_i[ax] <= 1'b1;
    @(posedge pclk);
    enc_i[ax] <= 1'b0;
  endtask
  task automatic hall(input logic [7:0] s, input logic [2:0] c);
    @(posedge pclk);
    din <= {93'h0, c} << (s - 8'h01);
  endtask
endmodule
`default_nettype wire

// ### bench/test_axis_commutation_amp_enable.sv
// Self-checking bench for the axis commutation and amplifier enable block.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_axis_commutation_amp_enable;
  logic pclk, presetn, psel, penable, pwrite, watchdog_trip, pready, pslverr, irq, er;
  logic [7:0] paddr, enc_a, enc_b, enc_i, amp_enable_out, m_comm, m_on;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0][15:0] pos_err_abs, axis_cmd, phase_b_cmd, dac_out;
  logic [95:0] digital_in;
  logic [15:0] lf;
  int fail_count, n_checks, m_ax, k;
  localparam logic [3:0] CAX [3] = '{4'h8, 4'h6, 4'h7};
  localparam logic [7:0] CCM [3] = '{8'h03, 8'h07, 8'h05};
  localparam logic [7:0] HS [3] = '{8'h06, 8'h11, 8'h51};
  localparam logic [2:0] HC [3] = '{3'h3, 3'h6, 3'h5};
  localparam logic [2:0] HX [3] = '{3'h1, 3'h3, 3'h5};
  localparam logic [39:0] BAD [4] = '{40'h0400000040, 40'h040000000F, 40'h2000070000,
    40'h240000005F};
  axis_commutation_amp_enable dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdog_trip(watchdog_trip),
    .pos_err_abs(pos_err_abs), .axis_cmd(axis_cmd), .phase_b_cmd(phase_b_cmd),
    .encoder_channel_a(enc_a), .encoder_channel_b(enc_b), .encoder_index(enc_i),
    .digital_in(digital_in), .dac_out(dac_out), .amp_enable_out(amp_enable_out), .irq(irq));
  axis_far_side far_u (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_i(enc_i),
    .din(digital_in));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ****
  // Bus, model and comparison tasks.
  // ****
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_checks++;
    if (got !== ex) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, ex, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      fail_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [31:0] absv(input logic [31:0] v);
    return v[31] ? 32'h0 - v : v;
  endfunction
  task automatic qpos(input int ax);
    wt(4);
    apb(1'b1, axis_amp_pkg::OFS_POS_QUERY, 32'(ax));
    apb(1'b0, axis_amp_pkg::OFS_POS_DATA, 32'h0);
  endtask
  task automatic chk_dac();
    logic [7:0][15:0] ex;
    int s, r;
    ex = '0;
    s = m_ax - $countones(m_comm);
    r = 0;
    for (int d = 0; d < 8; d++) begin
      if (d < s && !(m_comm[d] && !m_on[d])) ex[d] = axis_cmd[d];
      if (m_comm[d] && m_on[d]) ex[s + r] = phase_b_cmd[d];
      if (m_comm[d]) r++;
    end
    for (int d = 0; d < 8; d++) chk("dac", {16'h0, ex[d]}, {16'h0, dac_out[d]});
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    test_done();
  end
  // ****
  // Main sequence.
  // ****
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    watchdog_trip = 1'b0;
    pos_err_abs = '0;
    axis_cmd = '0;
    phase_b_cmd = '0;
    lf = 16'h0088;
    wt(8);
    presetn <= 1'b1;
    apb(1'b1, axis_amp_pkg::OFS_IRQ_ENABLE, 32'h1FF);
    apb(1'b0, axis_amp_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", 32'h08, rd & 32'h1F);
    apb(1'b0, axis_amp_pkg::OFS_ERR_LIMIT, 32'h0);
    chk("limit", 32'h07D0, rd & 32'hFFFF);
    apb(1'b0, 8'hFC, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b1, axis_amp_pkg::OFS_MOTOR, 32'hFF00);
    m_on = 8'hFF;
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 8; i++) begin
        lf = nxt(lf);
        axis_cmd[i] <= lf;
        lf = nxt(lf);
        phase_b_cmd[i] <= lf;
      end
      m_ax = int'(CAX[c]);
      m_comm = CCM[c];
      apb(1'b1, axis_amp_pkg::OFS_CTRL, {28'h0, CAX[c]});
      apb(1'b1, axis_amp_pkg::OFS_COMM_SEL, {24'h0, CCM[c]});
      wt(2);
      chk_dac();
      chk("amp", 32'hFF, {24'h0, amp_enable_out});
    end
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, BAD[b][39:32], BAD[b][31:0]);
      wt(2);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b0, axis_amp_pkg::OFS_IRQ_STATUS, 32'h0);
      chk("status", 32'h100, rd & 32'h1FF);
      apb(1'b1, axis_amp_pkg::OFS_IRQ_CLEAR, 32'h1FF);
      wt(2);
      chk("irq", 32'h0, {31'h0, irq});
    end
    apb(1'b0, axis_amp_pkg::OFS_COMM_SEL, 32'h0);
    chk("comm", 32'h05, rd & 32'hFF);
    apb(1'b1, axis_amp_pkg::OFS_IRQ_ENABLE, 32'h0FF);
    apb(1'b1, axis_amp_pkg::OFS_COMM_SEL, 32'h40);
    wt(2);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, axis_amp_pkg::OFS_IRQ_ENABLE, 32'h1FF);
    wt(2);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, axis_amp_pkg::OFS_MOTOR, 32'h0005);
    m_on = 8'hFA;
    wt(2);
    chk_dac();
    chk("amp", 32'hFA, {24'h0, amp_enable_out});
    apb(1'b1, axis_amp_pkg::OFS_MOTOR, 32'hFF00);
    apb(1'b1, axis_amp_pkg::OFS_OFF_ON_ERR, 32'h02);
    apb(1'b1, axis_amp_pkg::OFS_IRQ_CLEAR, 32'h1FF);
    pos_err_abs[1] <= 16'h07D0;
    wt(3);
    chk("amp", 32'hFF, {24'h0, amp_enable_out});
    pos_err_abs[1] <= 16'h07D1;
    wt(3);
    chk("amp", 32'hFD, {24'h0, amp_enable_out});
    apb(1'b0, axis_amp_pkg::OFS_IRQ_STATUS, 32'h0);
    chk("status", 32'h002, rd & 32'h1FF);
    pos_err_abs[1] <= 16'h0000;
    apb(1'b1, axis_amp_pkg::OFS_MOTOR, 32'hFF00);
    watchdog_trip <= 1'b1;
    wt(2);
    chk("amp", 32'h00, {24'h0, amp_enable_out});
    watchdog_trip <= 1'b0;
    wt(2);
    chk("amp", 32'h00, {24'h0, amp_enable_out});
    apb(1'b1, axis_amp_pkg::OFS_MOTOR, 32'hFF00);
    apb(1'b1, axis_amp_pkg::OFS_CTRL, 32'h18);
    wt(2);
    chk("amp", 32'h00, {24'h0, amp_enable_out});
    apb(1'b1, axis_amp_pkg::OFS_CTRL, 32'h08);
    wt(2);
    chk("amp", 32'hFF, {24'h0, amp_enable_out});
    for (int i = 0; i < 6; i++) far_u.quad(1, 1'b1);
    qpos(1);
    chk("pos", 32'h6, absv(rd));
    for (int i = 0; i < 6; i++) far_u.quad(1, 1'b0);
    qpos(1);
    chk("pos", 32'h0, rd);
    for (int i = 0; i < 5; i++) begin
      far_u.tog(3);
      qpos(3);
      chk("jitter", 32'h1, {31'h0, absv(rd) <= 32'h1});
    end
    apb(1'b1, axis_amp_pkg::OFS_ENC_MODE, 32'h04);
    for (int i = 0; i < 7; i++) far_u.pulse(2, i > 4);
    far_u.idx(2);
    qpos(2);
    chk("pulse", 32'h3, rd);
    apb(1'b0, axis_amp_pkg::OFS_INDEX_DATA, 32'h0);
    chk("index", 32'h3, rd);
    for (int h = 0; h < 3; h++) begin
      apb(1'b1, axis_amp_pkg::OFS_HALL_SEL0, 32'h0);
      far_u.hall(HS[h], HC[h]);
      apb(1'b1, axis_amp_pkg::OFS_HALL_SEL0, {8'h00, HS[h], 16'h0000});
      for (int p = 0; p < 20; p++) begin
        apb(1'b0, axis_amp_pkg::OFS_PHASE, 32'h0);
        if (rd[26] === 1'b1) break;
      end
      chk("hall", {28'h0, 1'b1, HX[h]}, {28'h0, rd[26], rd[8:6]});
    end
    apb(1'b1, axis_amp_pkg::OFS_PHASE, 32'h5);
    apb(1'b0, axis_amp_pkg::OFS_PHASE, 32'h0);
    chk("phase", 32'h5, rd & 32'h7);
    test_done();
  end
endmodule
`default_nettype wire
